//--- rtl/audio_cfg_consts.svh
`ifndef AUDIO_CFG_CONSTS_SVH
`define AUDIO_CFG_CONSTS_SVH

// ----------------------------------------------------------------
// register addresses and reset values
// ----------------------------------------------------------------
`define CLOCK_RATE_BASS_CONFIG_ADDR    8'h00
`define SERIAL_FORMAT_MUTE_CONFIG_ADDR 8'h01
`define CLOCK_RATE_BASS_CONFIG_RST     8'h83
`define SERIAL_FORMAT_MUTE_CONFIG_RST  8'h42

// ----------------------------------------------------------------
// field positions, first register
// ----------------------------------------------------------------
`define CLK_RATIO_LSB  0
`define CLK_RATIO_MSB  2
`define INTERP_LSB     3
`define INTERP_MSB     4
`define BASS_REDIR_BIT 5
`define HIGH_PASS_BIT  6
`define MAX_PWR_BIT    7

// ----------------------------------------------------------------
// field positions, second register
// ----------------------------------------------------------------
`define BYPASS_BIT     0
`define ZERO_MUTE_BIT  1
`define IN_FMT_LSB     2
`define IN_FMT_MSB     4
`define FB_BIT         5
`define ZERO_CROSS_BIT 6
`define LIM_BIT        7

// ----------------------------------------------------------------
// counts
// ----------------------------------------------------------------
`define ZERO_MUTE_COUNT 2048

`endif

//--- rtl/audio_cfg_pkg.sv
package audio_cfg_pkg;

   typedef enum logic [2:0] {
      FMT_I2S, FMT_LEFT_JUST, FMT_RJ16, FMT_RJ18, FMT_RJ20, FMT_RJ24,
      FMT_UNDEF6, FMT_UNDEF7
   } serial_format_t;

   typedef enum logic [1:0] {
      OS_X4, OS_X2, OS_X1, OS_UNDEF
   } interp_t;

   typedef enum logic [2:0] {
      RATIO_64, RATIO_128, RATIO_192, RATIO_256, RATIO_384,
      RATIO_512, RATIO_768
   } clock_ratio_t;

   typedef enum logic [1:0] {
      RATE_32K, RATE_44K1, RATE_48K, RATE_UNKNOWN
   } rate_family_t;

endpackage

//--- rtl/audio_clock_format_config.sv
`timescale 1ns/1ps
`include "audio_cfg_consts.svh"

// Functional notes
// - register 00h holds ratio, interpolation, redirect, correction
// - register 01h holds bypass, mute, format, order
// - sample rates 32 to 192 kHz supported
// - pick 65.536/90.3168/98.304 MHz processing clock
// - interpolation 00 ratio decode 128..768 fs
// - interpolation 01/10 ratio decode 64..384 fs
// - interpolation code gives x4, x2, pass-through
// - redirect bit feeds channel 6 from mix
// - power correction only in output modes 00/10
// - bypass skips biquads and tone stages
// - mute channel after 2048 consecutive zero samples
// - decode serial input format codes 000..101
// - first-bit order selects msb or lsb first
// - zero-crossing bit defers volume changes
// - limiter bit picks anti-clip or compression
// - power output mode 00 fixed, 10 full
module audio_clock_format_config #(
   parameter int CHANNELS  = 8,
   parameter int ZERO_RUN  = `ZERO_MUTE_COUNT
) (
   input  wire logic                          ref_clk,
   input  wire logic                          reset_n,
   input  wire logic                          reg_write,
   input  wire logic [7:0]                    reg_addr,
   input  wire logic [7:0]                    reg_wdata,
   output logic      [7:0]                    reg_rdata,
   input  wire logic [1:0]                    power_output_mode,
   input  wire logic [1:0]                    rate_family,
   input  wire logic                          sample_strobe,
   input  wire logic [CHANNELS-1:0]           sample_is_zero,
   output logic      [2:0]                    master_clock_ratio_select,
   output logic      [1:0]                    interpolation_ratio,
   output logic                               bass_redirect_enable,
   output logic                               high_pass_enable_bit,
   output logic                               max_power_correction,
   output logic                               correction_active,
   output logic                               dsp_bypass,
   output logic                               zero_detect_mute_enable,
   output logic      [2:0]                    serial_input_format,
   output logic                               serial_input_first_bit,
   output logic                               zero_cross_volume,
   output logic                               limiter_compression_mode,
   output audio_cfg_pkg::serial_format_t      format_decoded,
   output audio_cfg_pkg::interp_t             oversample,
   output audio_cfg_pkg::clock_ratio_t        xtal_ratio,
   output logic      [31:0]                   proc_clock_hz,
   output logic      [CHANNELS-1:0]           channel_auto_mute
);

   // ------------------------------------------------------------
   // configuration storage
   // ------------------------------------------------------------
   logic [7:0] clock_rate_bass_config;
   logic [7:0] serial_format_mute_config;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         clock_rate_bass_config    <= `CLOCK_RATE_BASS_CONFIG_RST;
         serial_format_mute_config <= `SERIAL_FORMAT_MUTE_CONFIG_RST;
      end else if (reg_write) begin
         if (reg_addr == `CLOCK_RATE_BASS_CONFIG_ADDR)
            clock_rate_bass_config <= reg_wdata;
         if (reg_addr == `SERIAL_FORMAT_MUTE_CONFIG_ADDR)
            serial_format_mute_config <= reg_wdata;
      end
   end

   // ------------------------------------------------------------
   // readback
   // ------------------------------------------------------------
   logic [7:0] next_rdata;

   always_comb begin
      unique case (reg_addr)
         `CLOCK_RATE_BASS_CONFIG_ADDR:
            next_rdata = clock_rate_bass_config;
         `SERIAL_FORMAT_MUTE_CONFIG_ADDR:
            next_rdata = serial_format_mute_config;
         default:
            next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n)
         reg_rdata <= 8'h00;
      else
         reg_rdata <= next_rdata;
   end

   // ------------------------------------------------------------
   // field outputs
   // ------------------------------------------------------------
   logic [1:0] mode_s1, mode_s2, rf_s1, rf_s2;

   // mode and rate straps come from other domains: two flops first
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         mode_s1 <= 2'h0;
         mode_s2 <= 2'h0;
         rf_s1   <= 2'h0;
         rf_s2   <= 2'h0;
      end else begin
         mode_s1 <= power_output_mode;
         mode_s2 <= mode_s1;
         rf_s1   <= rate_family;
         rf_s2   <= rf_s1;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         master_clock_ratio_select <= 3'h3;
         interpolation_ratio       <= 2'h0;
         bass_redirect_enable      <= 1'b0;
         high_pass_enable_bit      <= 1'b0;
         max_power_correction      <= 1'b1;
         correction_active         <= 1'b0;
         dsp_bypass                <= 1'b0;
         zero_detect_mute_enable   <= 1'b1;
         serial_input_format       <= 3'h0;
         serial_input_first_bit    <= 1'b0;
         zero_cross_volume         <= 1'b1;
         limiter_compression_mode  <= 1'b0;
      end else begin
         master_clock_ratio_select <=
            clock_rate_bass_config[`CLK_RATIO_MSB:`CLK_RATIO_LSB];
         interpolation_ratio <=
            clock_rate_bass_config[`INTERP_MSB:`INTERP_LSB];
         bass_redirect_enable <=
            clock_rate_bass_config[`BASS_REDIR_BIT];
         high_pass_enable_bit <=
            clock_rate_bass_config[`HIGH_PASS_BIT];
         max_power_correction <=
            clock_rate_bass_config[`MAX_PWR_BIT];
         // modes 01 and 11 are reserved: correction stays off there
         correction_active <= clock_rate_bass_config[`MAX_PWR_BIT] &&
            (mode_s2 == 2'h0 || mode_s2 == 2'h2);
         dsp_bypass <= serial_format_mute_config[`BYPASS_BIT];
         zero_detect_mute_enable <=
            serial_format_mute_config[`ZERO_MUTE_BIT];
         serial_input_format <=
            serial_format_mute_config[`IN_FMT_MSB:`IN_FMT_LSB];
         serial_input_first_bit <=
            serial_format_mute_config[`FB_BIT];
         zero_cross_volume <=
            serial_format_mute_config[`ZERO_CROSS_BIT];
         limiter_compression_mode <=
            serial_format_mute_config[`LIM_BIT];
      end
   end

   // ------------------------------------------------------------
   // decodes
   // ------------------------------------------------------------
   audio_cfg_pkg::clock_ratio_t next_ratio;
   logic [31:0]                 next_clk_hz;
   logic [2:0]                  ratio_code;
   logic [1:0]                  interp_code;

   assign ratio_code  = clock_rate_bass_config[`CLK_RATIO_MSB:`CLK_RATIO_LSB];
   assign interp_code = clock_rate_bass_config[`INTERP_MSB:`INTERP_LSB];

   always_comb begin
      next_ratio = audio_cfg_pkg::RATIO_128;
      if (interp_code == 2'h0) begin
         if (ratio_code[2])
            next_ratio = audio_cfg_pkg::RATIO_128;
         else if (ratio_code == 3'h3)
            next_ratio = audio_cfg_pkg::RATIO_256;
         else if (ratio_code == 3'h2)
            next_ratio = audio_cfg_pkg::RATIO_384;
         else if (ratio_code == 3'h1)
            next_ratio = audio_cfg_pkg::RATIO_512;
         else
            next_ratio = audio_cfg_pkg::RATIO_768;
      end else begin
         // code 11 undefined: reuse the 01/10 column
         if (ratio_code[2])
            next_ratio = audio_cfg_pkg::RATIO_64;
         else if (ratio_code == 3'h3)
            next_ratio = audio_cfg_pkg::RATIO_128;
         else if (ratio_code == 3'h2)
            next_ratio = audio_cfg_pkg::RATIO_192;
         else if (ratio_code == 3'h1)
            next_ratio = audio_cfg_pkg::RATIO_256;
         else
            next_ratio = audio_cfg_pkg::RATIO_384;
      end
   end

   always_comb begin
      unique case (rf_s2)
         2'h0:    next_clk_hz = 32'h03E80000;
         2'h1:    next_clk_hz = 32'h05622000;
         2'h2:    next_clk_hz = 32'h05DC0000;
         default: next_clk_hz = 32'h00000000;
      endcase
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         format_decoded <= audio_cfg_pkg::FMT_I2S;
         oversample     <= audio_cfg_pkg::OS_X4;
         xtal_ratio     <= audio_cfg_pkg::RATIO_256;
         proc_clock_hz  <= 32'd0;
      end else begin
         format_decoded <= audio_cfg_pkg::serial_format_t'(
            serial_format_mute_config[`IN_FMT_MSB:`IN_FMT_LSB]);
         oversample <= audio_cfg_pkg::interp_t'(interp_code);
         xtal_ratio    <= next_ratio;
         proc_clock_hz <= next_clk_hz;
      end
   end

   // ------------------------------------------------------------
   // zero-detect auto mute, one run counter per channel
   // ------------------------------------------------------------
   localparam int CW = $clog2(ZERO_RUN + 1);

   for (genvar c = 0; c < CHANNELS; c++) begin : g_zero
      logic [CW-1:0] run;
      always_ff @(posedge ref_clk or negedge reset_n) begin
         if (!reset_n) begin
            run                  <= '0;
            channel_auto_mute[c] <= 1'b0;
         end else begin
            if (sample_strobe) begin
               if (!sample_is_zero[c])
                  run <= '0;
               else if (run != CW'(ZERO_RUN))
                  run <= run + 1'b1;
            end
            // mute releases one clock after a nonzero sample clears the run
            channel_auto_mute[c] <= zero_detect_mute_enable &&
               run == CW'(ZERO_RUN);
         end
      end
   end

endmodule

//--- verification/host_model.sv
`timescale 1ns/1ps
// ------------------------------------------
// host side of the control port
// ------------------------------------------
module host_model (
   input  wire logic       ref_clk,
   input  wire logic [7:0] reg_rdata,
   output logic            reg_write,
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata,
   output logic      [1:0] rate_family
);
   initial begin
      reg_write = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      rate_family = 2'h0;
   end
   // waits out reg then flop so fields are settled on return
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(negedge ref_clk);
      reg_write <= 1'b0;
      reg_wdata <= ~d;
      repeat (2) @(negedge ref_clk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge ref_clk);
      reg_addr <= a;
      repeat (2) @(negedge ref_clk);
      d = reg_rdata;
   endtask
   // drives the rate family strap at the next falling edge
   task automatic set_rate(input logic [1:0] f);
      @(negedge ref_clk);
      rate_family <= f;
   endtask
endmodule

//--- verification/audio_cfg_props.sv
`timescale 1ns/1ps
module audio_cfg_props #(
   parameter int ZERO_RUN = 2048
) (
   input wire logic                          ref_clk,
   input wire logic                          reset_n,
   input wire logic                          reg_write,
   input wire logic [7:0]                    reg_addr,
   input wire logic [7:0]                    reg_wdata,
   input wire logic [7:0]                    reg_rdata,
   input wire logic [1:0]                    power_output_mode,
   input wire logic [1:0]                    rate_family,
   input wire logic                          sample_strobe,
   input wire logic [7:0]                    sample_is_zero,
   input wire logic [2:0]                    master_clock_ratio_select,
   input wire logic [1:0]                    interpolation_ratio,
   input wire logic                          bass_redirect_enable,
   input wire logic                          high_pass_enable_bit,
   input wire logic                          max_power_correction,
   input wire logic                          correction_active,
   input wire logic                          dsp_bypass,
   input wire logic                          zero_detect_mute_enable,
   input wire logic [2:0]                    serial_input_format,
   input wire logic                          serial_input_first_bit,
   input wire logic                          zero_cross_volume,
   input wire logic                          limiter_compression_mode,
   input wire audio_cfg_pkg::serial_format_t format_decoded,
   input wire audio_cfg_pkg::interp_t        oversample,
   input wire logic [31:0]                   proc_clock_hz,
   input wire logic [7:0]                    channel_auto_mute
);
   logic [15:0] zrun;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   // ------------------------------------------
   // zero run on channel 0, cleared by any nonzero sample
   // ------------------------------------------
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n)
         zrun <= 16'h0000;
      else if (sample_strobe)
         zrun <= sample_is_zero[0] ? zrun + 16'h0001 : 16'h0000;
   end
   sequence s_nonzero;
      sample_strobe && !sample_is_zero[0];
   endsequence
   // fields show the written byte two edges after the write edge
   property p_wr_a;
      reg_write && reg_addr == 8'h00 |-> ##2
      ({max_power_correction, high_pass_enable_bit, bass_redirect_enable,
        interpolation_ratio, master_clock_ratio_select} ==
       $past(reg_wdata, 2));
   endproperty
   property p_wr_b;
      reg_write && reg_addr == 8'h01 |-> ##2
      ({limiter_compression_mode, zero_cross_volume, serial_input_first_bit,
        serial_input_format, zero_detect_mute_enable, dsp_bypass} ==
       $past(reg_wdata, 2));
   endproperty
   a_wr_fields_a: assert property (p_wr_a) else $error("reg A fields");
   a_wr_fields_b: assert property (p_wr_b) else $error("reg B fields");
   a_unmapped_zero: assert property (reg_addr > 8'h01 |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_corr_mode: assert property (power_output_mode[0] [*5] |->
      !correction_active) else $error("correction in reserved mode");
   a_mute_count: assert property ($rose(channel_auto_mute[0]) |->
      zrun >= ZERO_RUN) else $error("mute before zero run");
   a_mute_clear: assert property (s_nonzero |-> ##[1:2]
      !channel_auto_mute[0]) else $error("mute held after data");
   a_mute_enable: assert property (!zero_detect_mute_enable [*3] |->
      channel_auto_mute == 8'h00) else $error("mute while off");
   a_clock_family: assert property (rate_family == 2'h1 [*5] |->
      proc_clock_hz == 32'h05622000) else $error("clock hz");
   a_decode_maps: assert property ($stable(serial_input_format) &&
      $stable(interpolation_ratio) [*3] |-> {format_decoded, oversample} ==
      {serial_input_format, interpolation_ratio})
      else $error("decode map");
endmodule
bind audio_clock_format_config audio_cfg_props #(.ZERO_RUN(ZERO_RUN)) u_props (
   .ref_clk, .reset_n, .reg_write, .reg_addr, .reg_wdata, .reg_rdata,
   .power_output_mode, .rate_family, .sample_strobe, .sample_is_zero,
   .master_clock_ratio_select, .interpolation_ratio, .bass_redirect_enable,
   .high_pass_enable_bit, .max_power_correction, .correction_active,
   .dsp_bypass, .zero_detect_mute_enable, .serial_input_format,
   .serial_input_first_bit, .zero_cross_volume, .limiter_compression_mode,
   .format_decoded, .oversample, .proc_clock_hz, .channel_auto_mute);

//--- verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   logic ref_clk, reset_n, reg_write, sample_strobe, correction_active;
   logic bass_redirect_enable, dsp_bypass;
   logic serial_input_first_bit, zero_cross_volume, limiter_compression_mode;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, sample_is_zero, d;
   logic [7:0] channel_auto_mute;
   logic [1:0] power_output_mode, rate_family;
   logic [31:0] proc_clock_hz;
   audio_cfg_pkg::serial_format_t format_decoded;
   audio_cfg_pkg::interp_t        oversample;
   audio_cfg_pkg::clock_ratio_t   xtal_ratio;
   logic [31:0] hz [4] = '{32'h03E80000, 32'h05622000, 32'h05DC0000, 32'h0};
   int fail_count = 0;
   int checks = 0;
   host_model u_host (.ref_clk(ref_clk), .reg_rdata(reg_rdata),
      .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .rate_family(rate_family));
   audio_clock_format_config #(.ZERO_RUN(8)) u_dut (.ref_clk(ref_clk),
      .reset_n(reset_n), .reg_write(reg_write), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rate_family(rate_family),
      .power_output_mode(power_output_mode), .sample_strobe(sample_strobe),
      .sample_is_zero(sample_is_zero), .master_clock_ratio_select(),
      .interpolation_ratio(), .bass_redirect_enable(bass_redirect_enable),
      .dsp_bypass(dsp_bypass),
      .high_pass_enable_bit(), .max_power_correction(),
      .correction_active(correction_active), .zero_detect_mute_enable(),
      .serial_input_format(), .serial_input_first_bit(serial_input_first_bit),
      .zero_cross_volume(zero_cross_volume), .xtal_ratio(xtal_ratio),
      .limiter_compression_mode(limiter_compression_mode),
      .format_decoded(format_decoded), .oversample(oversample),
      .proc_clock_hz(proc_clock_hz), .channel_auto_mute(channel_auto_mute));
   // ------------------------------------------
   // checking and scenarios
   // ------------------------------------------
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic give_verdict;
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   function automatic logic [2:0] ratio(input logic [1:0] r, logic [2:0] m);
      logic [2:0] k;
      k = m[2] ? 3'h0 : 3'h4 - m;
      if (r == 2'h0)
         k = (k == 3'h0) ? 3'h1 : k + 3'h2;
      return k;
   endfunction
   task automatic t_regs;
      u_host.rd(8'h00, d);
      chk(d, 8'h83);
      u_host.rd(8'h01, d);
      chk(d, 8'h42);
      u_host.wr(8'h00, 8'h7C);
      u_host.wr(8'h01, 8'hFF);
      u_host.wr(8'h02, 8'hA5);
      chk({oversample, format_decoded}, 5'h1F);
      chk({bass_redirect_enable, dsp_bypass}, 2'h3);
      u_host.rd(8'h00, d);
      chk(d, 8'h7C);
      u_host.rd(8'h01, d);
      chk(d, 8'hFF);
      u_host.rd(8'h02, d);
      chk(d, 8'h00);
   endtask
   task automatic t_fields;
      for (int i = 0; i < 24; i++) begin
         u_host.wr(8'h00, {3'h4, i[4:0]});
         chk(xtal_ratio, ratio(i[4:3], i[2:0]));
         chk(oversample, i[4:3]);
      end
      for (int i = 0; i < 8; i++) begin
         u_host.wr(8'h01, {i[2:0], i[2:0], 2'h0});
         chk(format_decoded, i[2:0]);
         chk({limiter_compression_mode, zero_cross_volume,
            serial_input_first_bit}, i[2:0]);
      end
      for (int i = 0; i < 4; i++) begin
         u_host.set_rate(i[1:0]);
         repeat (4) @(negedge ref_clk);
         chk(proc_clock_hz, hz[i]);
      end
   endtask
   task automatic t_corr;
      for (int i = 0; i < 8; i++) begin
         if (i[1:0] == 2'h0)
            u_host.wr(8'h00, {~i[2], 7'h03});
         power_output_mode <= i[1:0];
         repeat (5) @(negedge ref_clk);
         chk(correction_active, !i[2] && !i[0]);
      end
   endtask
   task automatic t_mute;
      u_host.wr(8'h01, 8'h02);
      for (int i = 0; i < 10; i++) begin
         sample_strobe <= 1'b1;
         sample_is_zero <= (i == 8) ? 8'hFE : 8'hFF;
         @(negedge ref_clk);
         sample_strobe <= 1'b0;
         repeat (2) @(negedge ref_clk);
         chk(channel_auto_mute,
             i < 7 ? 8'h00 : i == 7 ? 8'hFF : 8'hFE);
      end
      // saturated runs on channels 1..7 must not mute once disabled
      u_host.wr(8'h01, 8'h00);
      chk(channel_auto_mute, 8'h00);
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   initial begin
      reset_n = 1'b0;
      power_output_mode = 2'h0;
      sample_strobe = 1'b0;
      sample_is_zero = 8'h00;
      repeat (20) @(negedge ref_clk);
      reset_n = 1'b1;
      t_regs;
      t_fields;
      t_corr;
      t_mute;
      give_verdict;
   end
endmodule
